// ---- logic/can_cfg_pkg.sv ----
// can_cfg_pkg: register offsets, reset values, field positions and the
// carrier structs shared by the protocol configuration and status block.
// assumes a 16-bit register port addressed by byte offset.
package can_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_ERRCNT   = 8'h04;
  localparam logic [7:0] OFS_CLASSIC  = 8'h06;
  localparam logic [7:0] OFS_TEST     = 8'h0a;
  localparam logic [7:0] OFS_PRESC_X  = 8'h0c;
  localparam logic [7:0] OFS_FD_CTRL  = 8'h26;
  localparam logic [7:0] OFS_NOM_SEG  = 8'h28;
  localparam logic [7:0] OFS_NOM_PRE  = 8'h2a;

  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h0001;
  localparam logic [15:0] RST_CLASSIC = 16'h2301;
  localparam logic [15:0] RST_ZERO    = 16'h0000;

  // writable masks
  localparam logic [15:0] MASK_CONTROL = 16'h00ef;
  localparam logic [15:0] MASK_TEST    = 16'h007c;
  localparam logic [15:0] MASK_PRESC_X = 16'h000f;
  localparam logic [15:0] MASK_FD_PROT = 16'h807f;
  localparam logic [15:0] MASK_FD_OPEN = 16'h0300;
  localparam logic [15:0] MASK_NOM     = 16'h7fff;

  // control register bit positions
  localparam int CTL_INIT = 0;
  localparam int CTL_SIE  = 2;
  localparam int CTL_EIE  = 3;
  localparam int CTL_CCE  = 6;
  localparam int CTL_TEST = 7;

  // fd control bit positions
  localparam int FDC_FD_OPERATION_ENABLE = 0;
  localparam int FDC_BITRATE_SWITCH_ENABLE = 1;
  localparam int FDC_DELAY_COMP_ENABLE = 2;
  localparam int FDC_TDCN = 3;
  localparam int FDC_RESTRICTED_OPERATION_MODE = 4;
  localparam int FDC_INTEGRATION_EDGE_FILTER = 5;
  localparam int FDC_EXCEPTION_HANDLING_DISABLE = 6;
  localparam int FDC_PXE  = 7;
  localparam int FDC_BITRATE_SWITCH_REQUEST = 8;
  localparam int FDC_DATA_PHASE_STATUS_IRQ_ENABLE = 9;
  localparam int FDC_LEGACY_FD_FORMAT_SELECT = 15;

  // error codes and interrupt value
  localparam logic [2:0]  LEC_NONE    = 3'h0;
  localparam logic [2:0]  LEC_ACK     = 3'h3;
  localparam logic [2:0]  LEC_NOCHG   = 3'h7;
  localparam logic [15:0] IRQ_STATUS  = 16'h8000;
  localparam logic [5:0]  PRESC_X_MUL = 6'h3f; // extension weight is this plus one (0x40)

  // events reported by the protocol engine, one-cycle pulses and levels
  typedef struct packed {
    logic       lec_valid;   // pulse: lec_code is new
    logic [2:0] lec_code;
    logic       rx_done;     // pulse: frame received without error
    logic       tx_done;     // pulse: frame transmitted without error
    logic       data_phase_error_code_valid;  // pulse: data phase error code is new
    logic [2:0] data_phase_error_code_code;
    logic       bus_off;     // level
    logic       warning;     // level
    logic       passive;     // level
    logic       rx_passive;  // level
    logic [6:0] rx_count;
    logic [7:0] tx_count;
    logic       pex_event;   // pulse: protocol exception
    logic       integrating; // level: bus integration in progress
  } core_events_s;

  // effective bit timing, each field already plus one
  typedef struct packed {
    logic [10:0] tq_div;
    logic [8:0]  seg_before;
    logic [7:0]  seg_after;
    logic [7:0]  jump_width;
  } bit_timing_s;

  // operating options handed to the protocol engine
  typedef struct packed {
    logic       fd_operation_enable;
    logic       legacy_fd_format_select;
    logic       bitrate_switch_request;
    logic       bitrate_switch_enable;
    logic       exception_handling_disable;
    logic       integration_edge_filter;
    logic       restricted_operation_mode;
    logic       delay_comp_enable;
    logic       delay_fixed_mode;
    logic [1:0] tx_pin_control;
    logic       loop_back;
    logic       silent;
    logic       basic;
  } op_cfg_s;

endpackage

// ---- logic/can_rx_sync.sv ----
// can_rx_sync: three-stage synchroniser for the bus receive pin.
// assumes the pin is asynchronous to i_mclk; output changes once
// the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module can_rx_sync (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // only s2 reads s1; the agreement check looks at s2 and s3
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  // bus idles recessive, so reset to high
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= 4'hf;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.lvl;
endmodule
`default_nettype wire

// ---- logic/can_tq_gen.sv ----
// can_tq_gen: time quantum tick generator, one pulse every i_div clocks.
// assumes i_div is at least one; the count is compared with the current
// i_div every clock, so a change of divisor takes effect at once.
`timescale 1ns/100ps
`default_nettype none
module can_tq_gen #(
  parameter int DIV_W = 11
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } tq_s;

  tq_s st_reg;
  tq_s st_next;

  // count clocks; wrap when the programmed quantum length is reached
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt + 1'b1 >= i_div) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;
endmodule
`default_nettype wire

// ---- logic/can_proto_cfg.sv ----
// can_proto_cfg: protocol configuration and status registers of a CAN / CAN FD
// controller: status codes, status interrupt, bit timing selection, test
// register and FD options. assumes a 16-bit register port on i_mclk with
// single-cycle i_wr / i_rd strobes and events from the protocol engine.
//
// Functional notes
// R1: a transmitted frame without acknowledge sets last_error_code to 3
// R2: error-free reception or transmission clears last_error_code to 0
// R3: host may write 7 to last_error_code; it stays until a bus event
// R4: error and status-change events raise the status interrupt when enabled
// R5: passive changes and host writes never raise the status interrupt
// R6: reading the status register clears a pending status interrupt
// R7: error counter register shows rx_passive_flag, receive and transmit counts
// R8: classic timing and prescaler extension used only while FD operation is off
// R9: classic fields are applied plus one within their valid ranges
// R10: classic quantum is extension times 0x40 plus prescaler plus one clocks
// R11: four extension bits form the prescaler upper bits, up to 1023
// R12: protected timing registers take writes only with config change and init
// R13: test register writable only with test access; keep tx pins at 00 (tx pin bits 6:5 stay writable here)
// R14: legacy format select chooses non-ISO FD frames, else ISO frames
// R15: data phase code other than 7 raises the status interrupt when enabled
// R16: bit rate switch request and enable steer FD transmissions
// R17: protocol exception flag set by event, cleared by reading its register
// R18: exception handling disable makes the engine send an error frame
// R19: edge filter needs two dominant quanta for hard sync while integrating
// R20: delay compensation enable and fixed mode are passed to the engine
// R21: with FD operation on, classic frames use the nominal timing
// R22: nominal fields set the arbitration bit time of 4 to 385 quanta
// R23: nominal quantum is nominal_prescaler plus one clocks, prescaler 0 to 255
// R24: restricted mode stops error counter increments on protocol errors
`timescale 1ns/100ps
`default_nettype none
module can_proto_cfg
  import can_cfg_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [7:0]   i_addr,
  input  wire logic [15:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic         i_can_rx,
  input  wire core_events_s i_ev,
  output logic [15:0]       o_rdata,
  output logic [15:0]       o_int_code,
  output logic              o_init,
  output logic              o_err_count_hold,
  output logic              o_hard_sync,
  output logic              o_tq_tick,
  output bit_timing_s       o_timing,
  output op_cfg_s           o_cfg
);

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] control;
    logic [15:0] classic;
    logic [15:0] test;
    logic [15:0] presc_x;
    logic [15:0] fd_ctrl;
    logic [15:0] nom_seg;
    logic [15:0] nom_pre;
    logic        bus_off;
    logic        warning;
    logic        passive;
    logic        rx_ok;
    logic        tx_ok;
    logic [2:0]  last_error_code;
    logic        int_pend;
    logic        q_prev;
    logic        q_prev2;
    logic        hard_sync;
    bit_timing_s timing;
  } cfg_s;

  cfg_s        st_reg;
  cfg_s        st_next;
  logic        rx_level;
  logic        tq_tick;
  logic        wr_open;
  logic        int_trigger;
  logic [15:0] status_word;
  logic [15:0] errcnt_word;

  // pin receive level passes the three-stage synchroniser
  can_rx_sync u_rx_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_can_rx),
    .o_level (rx_level)
  );

  // quantum tick from the currently selected prescaler
  can_tq_gen #(
    .DIV_W (11)
  ) u_tq_gen (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_div   (st_reg.timing.tq_div),
    .o_tick  (tq_tick)
  );

  // decode shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_open = st_reg.control[CTL_CCE] & st_reg.control[CTL_INIT]; // R12

  assign status_word = {8'h00, st_reg.bus_off, st_reg.warning, st_reg.passive,
                        st_reg.rx_ok, st_reg.tx_ok, st_reg.last_error_code};
  // counters come live from the engine
  assign errcnt_word = {i_ev.rx_passive, i_ev.rx_count, i_ev.tx_count}; // R7

  // hardware causes of a status interrupt; passive and host writes absent
  assign int_trigger =
      (st_reg.control[CTL_EIE] & ((i_ev.bus_off != st_reg.bus_off) |
                                  (i_ev.warning != st_reg.warning))) |
      (st_reg.control[CTL_SIE] & ((i_ev.lec_valid & (i_ev.lec_code != LEC_NOCHG)) |
                                  i_ev.rx_done | i_ev.tx_done)) |
      (st_reg.fd_ctrl[FDC_DATA_PHASE_STATUS_IRQ_ENABLE] & i_ev.data_phase_error_code_valid &
       (i_ev.data_phase_error_code_code != LEC_NOCHG)); // R4 R5 R15

  // register writes, status updates, read side effects and timing selection
  always_comb begin
    st_next         = st_reg;
    st_next.bus_off = i_ev.bus_off;
    st_next.warning = i_ev.warning;
    st_next.passive = i_ev.passive;

    // host writes first so that bus events below take priority
    if (i_wr) begin
      if (hit(i_addr, OFS_CONTROL)) begin
        st_next.control = i_wdata & MASK_CONTROL;
      end
      if (hit(i_addr, OFS_STATUS)) begin
        st_next.rx_ok = i_wdata[4];
        st_next.tx_ok = i_wdata[3];
        st_next.last_error_code   = i_wdata[2:0]; // R3
      end
      if (hit(i_addr, OFS_TEST) && st_reg.control[CTL_TEST]) begin
        st_next.test = i_wdata & MASK_TEST; // R13
      end
      if (hit(i_addr, OFS_FD_CTRL)) begin
        st_next.fd_ctrl[FDC_BITRATE_SWITCH_REQUEST] = i_wdata[FDC_BITRATE_SWITCH_REQUEST];
        st_next.fd_ctrl[FDC_DATA_PHASE_STATUS_IRQ_ENABLE] = i_wdata[FDC_DATA_PHASE_STATUS_IRQ_ENABLE];
      end
      if (wr_open) begin
        if (hit(i_addr, OFS_CLASSIC)) begin
          st_next.classic = i_wdata & MASK_NOM;
          // segment before sample point has a floor of one
          if (i_wdata[11:8] == 4'h0) begin
            st_next.classic[11:8] = 4'h1; // R9
          end
        end
        if (hit(i_addr, OFS_PRESC_X)) begin
          st_next.presc_x = i_wdata & MASK_PRESC_X; // R11
        end
        if (hit(i_addr, OFS_FD_CTRL)) begin
          st_next.fd_ctrl = (st_reg.fd_ctrl & ~(MASK_FD_PROT & ~16'h0080)) |
                            (i_wdata & MASK_FD_PROT & ~16'h0080) |
                            (st_next.fd_ctrl & MASK_FD_OPEN); // R12
        end
        if (hit(i_addr, OFS_NOM_SEG)) begin
          st_next.nom_seg = i_wdata & MASK_NOM; // R22
        end
        if (hit(i_addr, OFS_NOM_PRE)) begin
          st_next.nom_pre = i_wdata & MASK_NOM; // R23
        end
      end
    end

    // bus events override host writes in the same cycle
    if (i_ev.rx_done) begin
      st_next.rx_ok = 1'b1;
    end
    if (i_ev.tx_done) begin
      st_next.tx_ok = 1'b1;
    end
    if (i_ev.rx_done || i_ev.tx_done) begin
      st_next.last_error_code = LEC_NONE; // R2
    end
    if (i_ev.lec_valid) begin
      st_next.last_error_code = i_ev.lec_code; // R1 R3
    end
    // going bus-off stops bus activity until software clears init
    if (i_ev.bus_off && !st_reg.bus_off) begin
      st_next.control[CTL_INIT] = 1'b1;
    end

    // read data and read side effects; set wins over clear
    st_next.rdata = 16'h0000;
    if (i_rd) begin
      if (hit(i_addr, OFS_CONTROL)) st_next.rdata = st_reg.control;
      if (hit(i_addr, OFS_STATUS)) begin
        st_next.rdata    = status_word;
        st_next.int_pend = 1'b0; // R6
      end
      if (hit(i_addr, OFS_ERRCNT))  st_next.rdata = errcnt_word;
      if (hit(i_addr, OFS_CLASSIC)) st_next.rdata = st_reg.classic;
      if (hit(i_addr, OFS_TEST))    st_next.rdata = st_reg.test | {8'h00, rx_level, 7'h00};
      if (hit(i_addr, OFS_PRESC_X)) st_next.rdata = st_reg.presc_x;
      if (hit(i_addr, OFS_FD_CTRL)) begin
        st_next.rdata             = st_reg.fd_ctrl;
        st_next.fd_ctrl[FDC_PXE] = 1'b0; // R17
      end
      if (hit(i_addr, OFS_NOM_SEG)) st_next.rdata = st_reg.nom_seg;
      if (hit(i_addr, OFS_NOM_PRE)) st_next.rdata = st_reg.nom_pre;
    end
    if (i_ev.pex_event) begin
      st_next.fd_ctrl[FDC_PXE] = 1'b1; // R17
    end
    if (int_trigger) begin
      st_next.int_pend = 1'b1; // R4 R15
    end

    // timing: classic fields only while FD operation is off
    if (!st_reg.fd_ctrl[FDC_FD_OPERATION_ENABLE]) begin
      st_next.timing.tq_div     = {1'b0, st_reg.presc_x[3:0], st_reg.classic[5:0]} +
                                  11'h001; // R8 R10 R11
      st_next.timing.seg_before = {5'h00, st_reg.classic[11:8]} + 9'h001; // R9
      st_next.timing.seg_after  = {5'h00, st_reg.classic[14:12]} + 8'h01;
      st_next.timing.jump_width = {6'h00, st_reg.classic[7:6]} + 8'h01;
    end else begin
      // nominal timing also serves classic frames sent under FD operation
      st_next.timing.tq_div     = {3'h0, st_reg.nom_pre[7:0]} + 11'h001; // R21 R23
      st_next.timing.seg_before = {1'b0, st_reg.nom_seg[7:0]} + 9'h001; // R22
      st_next.timing.seg_after  = {1'b0, st_reg.nom_seg[14:8]} + 8'h01;
      st_next.timing.jump_width = {1'b0, st_reg.nom_pre[14:8]} + 8'h01;
    end

    // hard sync edge during integration, sampled once per quantum
    st_next.hard_sync = 1'b0;
    if (tq_tick) begin
      st_next.q_prev  = rx_level;
      st_next.q_prev2 = st_reg.q_prev;
      if (i_ev.integrating && !rx_level) begin
        if (st_reg.fd_ctrl[FDC_INTEGRATION_EDGE_FILTER]) begin
          // a single dominant quantum may be a glitch, so wait for two
          st_next.hard_sync = !st_reg.q_prev && st_reg.q_prev2; // R19
        end else begin
          st_next.hard_sync = st_reg.q_prev;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg         <= '0;
      st_reg.control <= RST_CONTROL;
      st_reg.classic <= RST_CLASSIC;
      st_reg.q_prev  <= 1'b1;
      st_reg.q_prev2 <= 1'b1;
      st_reg.timing  <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state
  assign o_rdata          = st_reg.rdata;
  assign o_int_code       = st_reg.int_pend ? IRQ_STATUS : RST_ZERO;
  assign o_init           = st_reg.control[CTL_INIT];
  assign o_err_count_hold = st_reg.fd_ctrl[FDC_RESTRICTED_OPERATION_MODE]; // R24
  assign o_hard_sync      = st_reg.hard_sync;
  assign o_tq_tick        = tq_tick;
  assign o_timing         = st_reg.timing;
  assign o_cfg = '{fd_operation_enable:        st_reg.fd_ctrl[FDC_FD_OPERATION_ENABLE],
                   legacy_fd_format_select:    st_reg.fd_ctrl[FDC_LEGACY_FD_FORMAT_SELECT], // R14
                   bitrate_switch_request:     st_reg.fd_ctrl[FDC_BITRATE_SWITCH_REQUEST], // R16
                   bitrate_switch_enable:      st_reg.fd_ctrl[FDC_BITRATE_SWITCH_ENABLE],
                   exception_handling_disable: st_reg.fd_ctrl[FDC_EXCEPTION_HANDLING_DISABLE], // R18
                   integration_edge_filter:    st_reg.fd_ctrl[FDC_INTEGRATION_EDGE_FILTER],
                   restricted_operation_mode:  st_reg.fd_ctrl[FDC_RESTRICTED_OPERATION_MODE],
                   delay_comp_enable:          st_reg.fd_ctrl[FDC_DELAY_COMP_ENABLE], // R20
                   delay_fixed_mode:           st_reg.fd_ctrl[FDC_TDCN],
                   tx_pin_control:             st_reg.test[6:5], // R13
                   loop_back:                  st_reg.test[4],
                   silent:                     st_reg.test[3],
                   basic:                      st_reg.test[2]};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_ack_lec_code: // R1
    assert property (i_ev.lec_valid && i_ev.lec_code == LEC_ACK |=> st_reg.last_error_code == LEC_ACK)
      else $error("ack error not reported");
  a_lec_clear_ok: // R2
    assert property ((i_ev.rx_done || i_ev.tx_done) && !i_ev.lec_valid |=> st_reg.last_error_code == 3'h0)
      else $error("lec not cleared on good frame");
  a_lec_host_hold: // R3
    assert property (i_wr && hit(i_addr, OFS_STATUS) && i_wdata[2:0] == 3'h7 &&
                     !i_ev.lec_valid && !i_ev.rx_done && !i_ev.tx_done
                     |=> st_reg.last_error_code == 3'h7) else $error("host lec write lost");
  a_err_irq_set: // R4
    assert property (st_reg.control[CTL_EIE] && ($changed(i_ev.bus_off) ||
                     $changed(i_ev.warning)) && !i_rd
                     |=> o_int_code == 16'h8000) else $error("error interrupt missing");
  a_no_spur_irq: // R5
    assert property (!int_trigger && o_int_code == 16'h0000 |=> o_int_code == 16'h0000)
      else $error("spurious status interrupt");
  a_status_read_clr: // R6
    assert property (i_rd && hit(i_addr, OFS_STATUS) && !int_trigger
                     |=> o_int_code == 16'h0000) else $error("status read did not clear");
  a_protect_timing: // R12
    assert property (i_wr && hit(i_addr, OFS_CLASSIC) && !wr_open |=> $stable(st_reg.classic))
      else $error("protected write accepted");
  a_test_locked: // R13
    assert property (i_wr && hit(i_addr, OFS_TEST) && !st_reg.control[CTL_TEST]
                     |=> $stable(o_cfg.tx_pin_control)) else $error("test register unlocked");
  a_pex_sticky: // R17
    assert property (i_ev.pex_event |=> st_reg.fd_ctrl[FDC_PXE])
      else $error("exception flag not set");
  a_classic_div: // R10
    assert property (!st_reg.fd_ctrl[FDC_FD_OPERATION_ENABLE] && $stable(st_reg.classic) &&
                     $stable(st_reg.presc_x) |=> o_timing.tq_div ==
                     {1'b0, $past(st_reg.presc_x[3:0]), $past(st_reg.classic[5:0])} + 11'h001)
      else $error("classic quantum wrong");
endmodule
`default_nettype wire

// ---- test/can_bus_model.sv ----
// can_bus_model: protocol engine and bus stand-in that feeds the
// configuration block with events and a receive pin level.
// assumes the bench requests one event at a time with a one-cycle i_go.
`timescale 1ns/100ps
`default_nettype none
module can_bus_model
  import can_cfg_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_go,
  input  wire logic [2:0]   i_kind,
  input  wire logic         i_hold,
  input  wire logic         i_dom,
  output core_events_s      o_ev,
  output logic              o_rx
);
  // pin idles recessive high, the transceiver pulls it low on dominant
  assign o_rx = ~i_dom;

  // pulses last one cycle so the block never sees one event twice
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_ev <= '0;
    end else begin
      o_ev.lec_valid  <= 1'b0;
      o_ev.rx_done    <= 1'b0;
      o_ev.tx_done    <= 1'b0;
      o_ev.data_phase_error_code_valid <= 1'b0;
      o_ev.pex_event  <= 1'b0;
      // integration is modelled as lasting while the bench holds the bus dominant
      o_ev.integrating <= i_dom;
      if (i_go) begin
        case (i_kind)
          3'h0: begin
            o_ev.lec_valid <= 1'b1;
            o_ev.lec_code  <= LEC_ACK;
            if (!i_hold) o_ev.tx_count <= o_ev.tx_count + 8'h08;
          end
          3'h1: o_ev.rx_done <= 1'b1;
          3'h2: o_ev.tx_done <= 1'b1;
          3'h3: o_ev.warning <= ~o_ev.warning;
          3'h4: o_ev.passive <= ~o_ev.passive;
          3'h5: begin
            o_ev.data_phase_error_code_valid <= 1'b1;
            o_ev.data_phase_error_code_code  <= 3'h2;
          end
          3'h6: begin
            o_ev.data_phase_error_code_valid <= 1'b1;
            o_ev.data_phase_error_code_code  <= LEC_NOCHG;
          end
          default: o_ev.pex_event <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// tb: self-checking bench for the protocol configuration block.
// assumes single-cycle register strobes and the engine model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb
  import can_cfg_pkg::*;
();
  logic         i_mclk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic         i_wr = 1'b0;
  logic         i_rd = 1'b0;
  logic         go = 1'b0;
  logic         dom = 1'b0;
  logic [2:0]   kind = 3'h0;
  logic [7:0]   addr = 8'h00;
  logic [15:0]  wdata = 16'h0000;
  logic [15:0]  rdata, int_code;
  logic         init, hold, hsync, tick, rx;
  core_events_s ev;
  bit_timing_s  tim;
  op_cfg_s      cfg;
  int           fail_count = 0;
  int           n_tests = 0;

  can_proto_cfg u_can_proto_cfg (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .i_can_rx(rx), .i_ev(ev),
    .o_rdata(rdata), .o_int_code(int_code), .o_init(init), .o_err_count_hold(hold),
    .o_hard_sync(hsync), .o_tq_tick(tick), .o_timing(tim), .o_cfg(cfg));
  can_bus_model u_can_bus_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_go(go),
    .i_kind(kind), .i_hold(hold), .i_dom(dom), .o_ev(ev), .o_rx(rx));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // strobes rise after one edge and are taken at the next
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    addr  <= a;
    wdata <= d;
    i_wr  <= 1'b1;
    @(posedge i_mclk);
    i_wr  <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask

  task automatic fire(input logic [2:0] k);
    @(posedge i_mclk);
    kind <= k;
    go   <= 1'b1;
    @(posedge i_mclk);
    go   <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic tchk(input logic [15:0] d, b, a, j);
    chk("tq_div", d, 16'(tim.tq_div));
    chk("seg_before", b, 16'(tim.seg_before));
    chk("seg_after", a, 16'(tim.seg_after));
    chk("jump_width", j, 16'(tim.jump_width));
  endtask

  // bounded wait for the next quantum tick, n counts the cycles
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic s_reset();
    rchk("control", OFS_CONTROL, RST_CONTROL);
    rchk("classic", OFS_CLASSIC, RST_CLASSIC);
    rchk("unmapped", 8'h40, 16'h0000);
    chk("init", 16'h0001, 16'(init));
    tchk(16'd2, 16'd4, 16'd3, 16'd1);
  endtask

  task automatic s_status();
    wr(OFS_CONTROL, 16'h0005);
    fire(3'h0);
    chk("int ack", IRQ_STATUS, int_code);
    rchk("status ack", OFS_STATUS, 16'h0003);
    chk("int read", 16'h0000, int_code);
    rchk("errcnt", OFS_ERRCNT, 16'h0008);
    wr(OFS_STATUS, 16'h0007);
    settle();
    chk("int host", 16'h0000, int_code);
    rchk("status 7", OFS_STATUS, 16'h0007);
    fire(3'h1);
    chk("int rx", IRQ_STATUS, int_code);
    rchk("status rx", OFS_STATUS, 16'h0010);
    wr(OFS_CONTROL, 16'h0009);
    fire(3'h4);
    chk("int passive", 16'h0000, int_code);
    fire(3'h3);
    chk("int warn", IRQ_STATUS, int_code);
    rchk("status warn", OFS_STATUS, 16'h0070);
    chk("int clear", 16'h0000, int_code);
  endtask

  task automatic s_timing();
    int n;
    wr(OFS_CLASSIC, 16'h5983);
    rchk("protected", OFS_CLASSIC, RST_CLASSIC);
    wr(OFS_CONTROL, 16'h0041);
    wr(OFS_CLASSIC, 16'h5983);
    wr(OFS_PRESC_X, 16'h0002);
    settle();
    tchk(16'd132, 16'd10, 16'd6, 16'd3);
    wait_tick(n);
    wait_tick(n);
    wait_tick(n);
    chk("tq period", 16'd132, 16'(n));
    wr(OFS_PRESC_X, 16'h000f);
    wr(OFS_CLASSIC, 16'h59bf);
    settle();
    chk("div max", 16'd1024, 16'(tim.tq_div));
  endtask

  task automatic s_fd();
    wr(OFS_FD_CTRL, 16'h837f);
    wr(OFS_NOM_SEG, 16'h0a14);
    wr(OFS_NOM_PRE, 16'h02ff);
    settle();
    chk("cfg fd", 16'h3fe0, 16'(cfg));
    tchk(16'd256, 16'd21, 16'd11, 16'd3);
    fire(3'h0);
    wr(OFS_ERRCNT, 16'hffff);
    rchk("errcnt hold", OFS_ERRCNT, 16'h0008);
    wr(OFS_CONTROL, 16'h0001);
    wr(OFS_FD_CTRL, 16'h0000);
    rchk("fd locked", OFS_FD_CTRL, 16'h807f);
    chk("cfg open", 16'h37e0, 16'(cfg));
    wr(OFS_CONTROL, 16'h0041);
    wr(OFS_FD_CTRL, 16'h0200);
    settle();
    chk("div classic", 16'd1024, 16'(tim.tq_div));
    fire(3'h5);
    chk("int data_phase_error_code", IRQ_STATUS, int_code);
    rchk("status any", OFS_STATUS, 16'h0073);
    fire(3'h6);
    chk("int data_phase_error_code 7", 16'h0000, int_code);
    fire(3'h7);
    rchk("pex set", OFS_FD_CTRL, 16'h0280);
    rchk("pex clear", OFS_FD_CTRL, 16'h0200);
  endtask

  task automatic s_test();
    int hs;
    hs = 0;
    wr(OFS_TEST, 16'h001c);
    rchk("test locked", OFS_TEST, 16'h0080);
    wr(OFS_CONTROL, 16'h0081);
    wr(OFS_TEST, 16'h001c);
    rchk("test open", OFS_TEST, 16'h009c);
    chk("cfg test", 16'h0007, 16'(cfg));
    @(posedge i_mclk);
    dom <= 1'b1;
    // one quantum of 1024 clocks must pass; without the filter one edge gives one pulse
    repeat (1100) begin
      @(posedge i_mclk);
      #1;
      if (hsync === 1'b1) hs++;
    end
    chk("hard sync", 16'h0001, 16'(hs));
    rchk("test rx", OFS_TEST, 16'h001c);
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    settle();
    s_reset();
    s_status();
    s_timing();
    s_fd();
    s_test();
    stop_test();
  end
endmodule
`default_nettype wire
